// file: verilog/hvm_pkg.sv
package hvm_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00; // Configuration.
   localparam logic [7:0] OFS_SCHED  = 8'h04; // Schedule and override.
   localparam logic [7:0] OFS_WINDOW = 8'h08; // Window contacts A and B.
   localparam logic [7:0] OFS_PRES   = 8'h0c; // Raw presence contacts.
   localparam logic [7:0] OFS_COND   = 8'h10; // Alarm, cooling, demand.
   localparam logic [7:0] OFS_SURF   = 8'h14; // Surface temperature.
   localparam logic [7:0] OFS_THR    = 8'h18; // Surface threshold.
   localparam logic [7:0] OFS_TEMP   = 8'h1c; // Two room temperatures.
   localparam logic [7:0] OFS_DELAY  = 8'h20; // Window and absence times.
   localparam logic [7:0] OFS_STATUS = 8'h24; // Valve close, window force.
   localparam logic [7:0] OFS_MODE   = 8'h28; // Mode of each channel.
   localparam logic [7:0] OFS_MIX    = 8'h2c; // Weighted temperature.

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int CTRL_CTL_EN   = 0;  // Integrated controller role.
   localparam int CTRL_SURF_EN  = 1;  // Surface limitation enable.
   localparam int CTRL_WIN_OR   = 2;  // OR second window contact in.
   localparam int CTRL_PRES_INV = 3;  // Inverted presence polarity.
   localparam int CTRL_PMODE    = 4;  // Two bits: extend, limit.
   localparam int CTRL_ATT_ECO  = 6;  // Attenuated mode is economy.
   localparam int CTRL_WEIGHT   = 8;  // Five bits, weight of A in 16ths.
   localparam int SCHED_OVR     = 4;  // Three bit override mode.

   // ----------------------------------------------------------------
   // Reset values; temperatures are in units of 0.1 degree.
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST  = 32'h0000_0801;
   localparam logic [31:0] SCHED_RST = 32'h0000_0001;
   localparam logic [15:0] THR_RST   = 16'h0122; // 29.0 degrees.
   localparam logic [15:0] HYST      = 16'h0003; // 0.3 kelvin.
   localparam logic [31:0] DELAY_RST = 32'h0000_0000;
   localparam logic [4:0]  WEIGHT_FULL = 5'h10;

   // ----------------------------------------------------------------
   // Operating mode codes and timing.
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_AUTO    = 3'h0;
   localparam logic [2:0] MODE_COMFORT = 3'h1;
   localparam logic [2:0] MODE_STANDBY = 3'h2;
   localparam logic [2:0] MODE_ECONOMY = 3'h3;
   localparam logic [2:0] MODE_PROTECT = 3'h4;

   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_TIME_US  = 1000; // Delay timers count in ms.
   localparam int TICK_CYCLES   = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;

   // Presence handling state of one channel.
   typedef enum logic [1:0] {PS_IDLE, PS_EXTEND, PS_LIMIT} hvm_pres_t;

endpackage

// file: verilog/hvm_chan.sv
`timescale 1ns/1ps
module hvm_chan (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        ctl_en,
   input  wire logic        win_or,
   input  wire logic        pres_inv,
   input  wire logic [1:0]  pres_mode,
   input  wire logic        att_eco,
   input  wire logic        win_a,
   input  wire logic        win_b,
   input  wire logic        pres_raw,
   input  wire logic [2:0]  sched,
   input  wire logic [2:0]  override,
   input  wire logic [15:0] win_dly,
   input  wire logic [15:0] abs_time,
   output logic      [2:0]  mode_q,
   output logic             win_forced_q
);

   logic             pres;      // Occupancy after polarity.
   logic             win_open;  // Combined window condition.
   logic             abs_exp;   // Absence outlasted the preset time.
   logic [15:0]      win_cnt_q; // Window open time in ticks.
   logic [15:0]      abs_cnt_q; // Absence time in ticks.
   logic [2:0]       pres_md;   // Mode proposed by presence handling.
   logic [2:0]       mode_d;    // Arbitrated mode.
   hvm_pkg::hvm_pres_t st_q;    // Presence handling state.

   // Polarity: a closed contact means presence unless inverted.
   assign pres = pres_raw ^ pres_inv;

   // Window handling only exists in the controller role.
   assign win_open = ctl_en & (win_a | (win_or & win_b));

   assign abs_exp = !pres && (abs_cnt_q >= abs_time);

   // ----------------------------------------------------------------
   // Opening delay timer; restarts on every closing so short
   // openings never force the mode.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         win_cnt_q <= 16'h0000;
      else if (!win_open)
         win_cnt_q <= 16'h0000;
      else if (tick && win_cnt_q != 16'hffff)
         win_cnt_q <= win_cnt_q + 16'h0001;
   end

   // Force holds while window A, or B when ORed in, is open past the delay.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         win_forced_q <= 1'b0;
      else
         win_forced_q <= win_open && (win_cnt_q >= win_dly);
   end

   // Absence timer, cleared whenever presence is reported.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         abs_cnt_q <= 16'h0000;
      else if (pres)
         abs_cnt_q <= 16'h0000;
      else if (tick && abs_cnt_q != 16'hffff)
         abs_cnt_q <= abs_cnt_q + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Presence handling. Both modes may be enabled at once; they
   // only ever start from an actual comfort mode.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= hvm_pkg::PS_IDLE;
      else
      begin
         case (st_q)
            hvm_pkg::PS_IDLE:
            begin
               // Presence outside comfort starts nothing.
               if (ctl_en && pres_mode[0] && pres &&
                   mode_q == hvm_pkg::MODE_COMFORT)
                  st_q <= hvm_pkg::PS_EXTEND;
               else if (ctl_en && pres_mode[1] && abs_exp &&
                        mode_q == hvm_pkg::MODE_COMFORT)
                  st_q <= hvm_pkg::PS_LIMIT;
            end
            hvm_pkg::PS_EXTEND:
            begin
               // Short absences keep comfort; long ones end it.
               if (!ctl_en || !pres_mode[0] || abs_exp)
                  st_q <= hvm_pkg::PS_IDLE;
            end
            hvm_pkg::PS_LIMIT:
            begin
               // Leave once someone returns or the schedule moves on.
               if (!ctl_en || !pres_mode[1] || pres ||
                   sched != hvm_pkg::MODE_COMFORT)
                  st_q <= hvm_pkg::PS_IDLE;
            end
            default:
               st_q <= hvm_pkg::PS_IDLE;
         endcase
      end
   end

   // Presence proposal; the attenuated mode is a configuration.
   always_comb
   begin
      case (st_q)
         hvm_pkg::PS_EXTEND: pres_md = hvm_pkg::MODE_COMFORT;
         hvm_pkg::PS_LIMIT:  pres_md = att_eco ? hvm_pkg::MODE_ECONOMY
                                      : hvm_pkg::MODE_STANDBY;
         default:   pres_md = sched;
      endcase
   end

   // Window beats override, override beats presence and schedule.
   // The previous mode returns by itself when the window closes.
   always_comb
   begin
      if (win_forced_q)
         mode_d = hvm_pkg::MODE_PROTECT;
      else if (override != hvm_pkg::MODE_AUTO)
         mode_d = override;
      else
         mode_d = pres_md;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= hvm_pkg::MODE_COMFORT;
      else
         mode_q <= mode_d;
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   window_prot_a: assert property (win_forced_q |=>
      mode_q == hvm_pkg::MODE_PROTECT)
      else $error("open window did not force protection");
   window_release_a: assert property (!win_open |=>
      !win_forced_q)
      else $error("window force outlived the open window");
   override_wins_a: assert property (!win_forced_q &&
      override != hvm_pkg::MODE_AUTO |=> mode_q == $past(override))
      else $error("override mode not applied");
   extend_hold_a: assert property (st_q == hvm_pkg::PS_EXTEND &&
      !win_forced_q && override == hvm_pkg::MODE_AUTO |=>
      mode_q == hvm_pkg::MODE_COMFORT)
      else $error("comfort extension did not hold comfort");
   short_open_a: assert property (win_open &&
      win_cnt_q < win_dly |=> !win_forced_q)
      else $error("window forced before delay expired");

endmodule

// file: verilog/hvm_mode_arbiter.sv
`timescale 1ns/1ps
module hvm_mode_arbiter #(
   parameter int TICK_CYCLES = hvm_pkg::TICK_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [7:0]  valve_close,
   output logic      [23:0] chan_mode,
   output logic      [15:0] temp_mix
);

   // ----------------------------------------------------------------
   // Storage.
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;      // Configuration bits.
   logic [31:0] sched_q;     // Scheduled mode and override mode.
   logic [15:0] win_q;       // Contacts A in [7:0], B in [15:8].
   logic [7:0]  pres_q;      // Raw presence contacts.
   logic [23:0] cond_q;      // Alarm, cooling flag, demand flag.
   logic [15:0] surf_q;      // Signed surface temperature.
   logic [15:0] thr_q;       // Signed surface threshold.
   logic [31:0] temp_q;      // Temperature A low half, B high half.
   logic [31:0] dly_q;       // Window delay low, absence time high.
   logic [7:0]  win_frc;     // Window force of each channel.
   logic [23:0] mode_w;      // Modes from the channel logic.
   logic        hot_q;       // Surface over-temperature latch.
   logic        tick_q;      // One-cycle pulse per millisecond.
   logic [31:0] tick_cnt_q;  // Tick divider.
   logic [31:0] rd_d;        // Read data for the addressed word.
   logic        hit;         // Address is mapped.
   logic        setup;       // APB setup phase.
   logic        wr;          // Write takes effect this edge.

   // ----------------------------------------------------------------
   // APB slave: one wait-free access cycle after setup.
   // ----------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr    = psel && penable && pready && pwrite && hit;

   // Address decode and read multiplexer.
   always_comb
   begin
      hit  = 1'b1;
      rd_d = 32'h0000_0000;
      case (paddr)
         hvm_pkg::OFS_CTRL:   rd_d = ctrl_q;
         hvm_pkg::OFS_SCHED:  rd_d = sched_q;
         hvm_pkg::OFS_WINDOW: rd_d = {16'h0000, win_q};
         hvm_pkg::OFS_PRES:   rd_d = {24'h00_0000, pres_q};
         hvm_pkg::OFS_COND:   rd_d = {8'h00, cond_q};
         hvm_pkg::OFS_SURF:   rd_d = {16'h0000, surf_q};
         hvm_pkg::OFS_THR:    rd_d = {16'h0000, thr_q};
         hvm_pkg::OFS_TEMP:   rd_d = temp_q;
         hvm_pkg::OFS_DELAY:  rd_d = dly_q;
         hvm_pkg::OFS_STATUS: rd_d = {15'h0000, hot_q, win_frc,
                                      valve_close};
         hvm_pkg::OFS_MODE:   rd_d = {8'h00, chan_mode};
         hvm_pkg::OFS_MIX:    rd_d = {16'h0000, temp_mix};
         default:             hit  = 1'b0;
      endcase
   end

   // Ready and error rise for the single access cycle only.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !hit;
         // Sampled in setup so prdata is a flop during access.
         if (setup)
            prdata <= (hit && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Writable registers. Read-only words ignore writes.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q  <= hvm_pkg::CTRL_RST;
         sched_q <= hvm_pkg::SCHED_RST;
         win_q   <= 16'h0000;
         pres_q  <= 8'h00;
         cond_q  <= 24'h00_0000;
         surf_q  <= 16'h0000;
         thr_q   <= hvm_pkg::THR_RST;
         temp_q  <= 32'h0000_0000;
         dly_q   <= hvm_pkg::DELAY_RST;
      end
      else if (wr)
      begin
         case (paddr)
            hvm_pkg::OFS_CTRL:   ctrl_q  <= pwdata & 32'h0000_1fff;
            hvm_pkg::OFS_SCHED:  sched_q <= pwdata & 32'h0000_0077;
            hvm_pkg::OFS_WINDOW: win_q   <= pwdata[15:0];
            hvm_pkg::OFS_PRES:   pres_q  <= pwdata[7:0];
            hvm_pkg::OFS_COND:   cond_q  <= pwdata[23:0];
            hvm_pkg::OFS_SURF:   surf_q  <= pwdata[15:0];
            hvm_pkg::OFS_THR:    thr_q   <= pwdata[15:0];
            hvm_pkg::OFS_TEMP:   temp_q  <= pwdata;
            hvm_pkg::OFS_DELAY:  dly_q   <= pwdata;
            default:             ctrl_q  <= ctrl_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Millisecond tick shared by all channel timers. The count is a
   // parameter so simulation can shorten it.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q >= 32'(TICK_CYCLES - 1))
      begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Surface limitation with hysteresis. A disabled function drops
   // the latch at once so the valves are never held shut by it.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hot_q <= 1'b0;
      else if (!ctrl_q[hvm_pkg::CTRL_SURF_EN])
         hot_q <= 1'b0;
      else if ($signed(surf_q) > $signed(thr_q))
         hot_q <= 1'b1;
      else if ($signed(surf_q) < $signed(thr_q - hvm_pkg::HYST))
         hot_q <= 1'b0;
   end

   // Valve closing: surface latch, or condensation while cooling
   // and demanding. That term lifts as soon as the alarm bit clears.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         valve_close <= 8'h00;
      else
         valve_close <= {8{hot_q}} |
                        (cond_q[7:0] & cond_q[15:8] & cond_q[23:16]);
   end

   // ----------------------------------------------------------------
   // Weighted mean: A gets weight/16, B the rest. A weight of 16
   // or more uses A alone; arithmetic truncates toward minus.
   // ----------------------------------------------------------------
   logic [4:0]         wgt;
   logic signed [22:0] mix_sum;

   always_comb
   begin
      wgt = ctrl_q[hvm_pkg::CTRL_WEIGHT +: 5];
      if (wgt > hvm_pkg::WEIGHT_FULL)
         wgt = hvm_pkg::WEIGHT_FULL;
      mix_sum = 23'($signed(temp_q[15:0]) * $signed({1'b0, wgt})) +
                23'($signed(temp_q[31:16]) *
                    $signed({1'b0, hvm_pkg::WEIGHT_FULL - wgt}));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         temp_mix <= 16'h0000;
      else
         temp_mix <= mix_sum[19:4];
   end

   // ----------------------------------------------------------------
   // Eight channel arbiters sharing configuration and the millisecond tick.
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_chan
         hvm_chan u_chan (
            .pclk         (pclk),
            .presetn      (presetn),
            .tick         (tick_q),
            .ctl_en       (ctrl_q[hvm_pkg::CTRL_CTL_EN]),
            .win_or       (ctrl_q[hvm_pkg::CTRL_WIN_OR]),
            .pres_inv     (ctrl_q[hvm_pkg::CTRL_PRES_INV]),
            .pres_mode    (ctrl_q[hvm_pkg::CTRL_PMODE +: 2]),
            .att_eco      (ctrl_q[hvm_pkg::CTRL_ATT_ECO]),
            .win_a        (win_q[g]),
            .win_b        (win_q[g + 8]),
            .pres_raw     (pres_q[g]),
            .sched        (sched_q[2:0]),
            .override     (sched_q[hvm_pkg::SCHED_OVR +: 3]),
            .win_dly      (dly_q[15:0]),
            .abs_time     (dly_q[31:16]),
            .mode_q       (mode_w[3*g +: 3]),
            .win_forced_q (win_frc[g])
         );
      end
   endgenerate

   // Registered copy of the modes for the output port.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         chan_mode <= {8{hvm_pkg::MODE_COMFORT}};
      else
         chan_mode <= mode_w;
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_hot;
      ctrl_q[hvm_pkg::CTRL_SURF_EN] && $signed(surf_q) > $signed(thr_q);
   endsequence

   surf_close_a: assert property (s_hot ##1 1'b1 |=>
      valve_close == 8'hff)
      else $error("surface over-temperature did not close valves");
   surf_hyst_a: assert property (hot_q &&
      ctrl_q[hvm_pkg::CTRL_SURF_EN] &&
      $signed(surf_q) >= $signed(thr_q - hvm_pkg::HYST) |=> hot_q)
      else $error("surface latch released inside hysteresis");
   // The valve word follows latch and alarm terms of the cycle before.
   cond_close_a: assert property (!hot_q ##1 !hot_q &&
      (cond_q[7:0] & cond_q[15:8] & cond_q[23:16]) == 8'h00 |=>
      valve_close == 8'h00)
      else $error("valve closed without cause");
   apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access cycle");

endmodule

// file: verification/hvm_sup.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Supervisor model: moves bus objects to and from the block as APB writes and reads.
// ----------------------------------------------------------------
module hvm_sup (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic      [7:0]  paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata
);
   // The bus idles with no request at time zero.
   initial
   begin
      paddr   = 8'h00;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      pwdata  = 32'h0;
   end
   // One transfer, held until pready is sampled high; the wait is bounded.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released data no longer shows the old word.
      pwdata  <= ~d;
   endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // Row: write offset and word, then read offset and expected word.
   typedef struct packed
   {
      logic [7:0] wa;
      logic [31:0] wd;
      logic [7:0] ra;
      logic [31:0] ex;
   } hvm_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [31:0] pwdata, prdata, rd;
   logic        err;
   logic [7:0]  valve_close;
   logic [23:0] chan_mode;
   logic [15:0] temp_mix;
   int          fails = 0;
   int          checks = 0;
   hvm_row_t    rows [30] = '{
      '{8'h00, 32'h803, 8'h24, 32'h0},
      '{8'h10, 32'h10101, 8'h24, 32'h1},
      '{8'h10, 32'h30103, 8'h24, 32'h1},
      '{8'h10, 32'h0, 8'h24, 32'h0},
      '{8'h14, 32'h122, 8'h24, 32'h0},
      '{8'h14, 32'h123, 8'h24, 32'h100ff},
      '{8'h14, 32'h120, 8'h24, 32'h100ff},
      '{8'h14, 32'h11e, 8'h24, 32'h0},
      '{8'h1c, 32'hf000c8, 8'h2c, 32'hdc},
      '{8'h00, 32'h1013, 8'h2c, 32'hc8},
      '{8'h0c, 32'hff, 8'h28, 32'h249249},
      '{8'h04, 32'h3, 8'h28, 32'h249249},
      '{8'h0c, 32'h0, 8'h28, 32'h6db6db},
      '{8'h0c, 32'hff, 8'h28, 32'h6db6db},
      '{8'h04, 32'h21, 8'h28, 32'h492492},
      '{8'h04, 32'h1, 8'h28, 32'h249249},
      '{8'h00, 32'h1063, 8'h28, 32'h249249},
      '{8'h0c, 32'h0, 8'h28, 32'h6db6db},
      '{8'h00, 32'h107b, 8'h28, 32'h249249},
      '{8'h04, 32'h3, 8'h28, 32'h249249},
      '{8'h0c, 32'hff, 8'h28, 32'h6db6db},
      '{8'h00, 32'h1007, 8'h28, 32'h6db6db},
      '{8'h04, 32'h21, 8'h28, 32'h492492},
      '{8'h08, 32'h1, 8'h28, 32'h492494},
      '{8'h08, 32'h201, 8'h28, 32'h4924a4},
      '{8'h08, 32'h100, 8'h28, 32'h492494},
      '{8'h08, 32'h0, 8'h28, 32'h492492},
      '{8'h00, 32'h1006, 8'h28, 32'h492492},
      '{8'h08, 32'hff, 8'h28, 32'h492492},
      '{8'h08, 32'h0, 8'h24, 32'h0}};
   // ----------------------------------------------------------------
   // Clock, design, supervisor model.
   // ----------------------------------------------------------------
   always #2 pclk = ~pclk;
   hvm_mode_arbiter #(.TICK_CYCLES(4)) i_dut (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .valve_close(valve_close),
      .chan_mode(chan_mode), .temp_mix(temp_mix));
   hvm_sup i_sup (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata));
   // Compare one value and count it.
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   // Verdict and end of run.
   task automatic end_of_test();
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Write, then let the mode pipeline settle for three cycles.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_sup.xfer(1'b1, a, d, rd, err);
      repeat (3) @(posedge pclk);
   endtask
   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].wa, rows[i].wd);
         i_sup.xfer(1'b0, rows[i].ra, 32'h0, rd, err);
         chk($sformatf("row %0d", i), rows[i].ex, rd);
      end
      // A second reset in mid-run returns modes to comfort and clears valves at once.
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      chk("rst mode", 32'h249249, {8'h0, chan_mode});
      chk("rst valve", 32'h0, {24'h0, valve_close});
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      i_sup.xfer(1'b0, hvm_pkg::OFS_CTRL, 32'h0, rd, err);
      chk("ctrl rst", 32'h801, rd);
      i_sup.xfer(1'b0, hvm_pkg::OFS_THR, 32'h0, rd, err);
      chk("thr rst", 32'h122, rd);
      // Unmapped place: refused, nothing stored, zero read.
      i_sup.xfer(1'b1, 8'h30, 32'h5a5a5a5a, rd, err);
      chk("unmapped wr err", 32'h1, {31'h0, err});
      i_sup.xfer(1'b0, 8'h30, 32'h0, rd, err);
      chk("unmapped rd", 32'h1, {rd[30:0], err});
      // Two tick opening delay: a short opening is ignored.
      wr(hvm_pkg::OFS_CTRL, 32'h1007);
      wr(hvm_pkg::OFS_SCHED, 32'h21);
      wr(hvm_pkg::OFS_DELAY, 32'h2);
      i_sup.xfer(1'b1, hvm_pkg::OFS_WINDOW, 32'h1, rd, err);
      wr(hvm_pkg::OFS_WINDOW, 32'h0);
      repeat (16) @(posedge pclk);
      chk("short open", {29'h0, hvm_pkg::MODE_STANDBY}, chan_mode[2:0]);
      wr(hvm_pkg::OFS_WINDOW, 32'h1);
      repeat (16) @(posedge pclk);
      chk("long open", {29'h0, hvm_pkg::MODE_PROTECT}, chan_mode[2:0]);
      end_of_test();
   end
   // Watchdog: the whole run needs well under 2000 cycles.
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails++;
      end_of_test();
   end
endmodule
